// [rtl/fcfir_chain.sv]
/*
  three fir stages in series, each followed by a fifo, with valid
  flags forward and a locally delayed ready back toward each stage.
  assumes upstream and downstream logic on the same clock; no pin
  synchronisers are needed.
*/
`timescale 1ns/100ps
// Overview of operation
// RULE_01 - three fir stages in series, each followed by its own fifo
// RULE_02 - fifo at half capacity drops ready toward the stage before
// RULE_03 - a stage takes no valid input while its ready is low
// RULE_04 - fifo shows oldest word with valid high whenever it holds one
// RULE_05 - head leaves only when fifo valid and consumer ready both high
// RULE_06 - each ready goes back one stage only
// RULE_07 - ready feedback delay is at least the stage latency
// RULE_08 - fifo keeps room for the delay's worth of words past threshold
// RULE_09 - last fifo drains on the external downstream ready
// RULE_10 - stage state holds when incoming valid is low
// RULE_11 - tap line is single-cycle registers shifting on valid
// RULE_12 - only registers are enabled; multiply and add run freely
// RULE_13 - valid travels with the data; data counts only when valid
// RULE_14 - reset empties fifos, clears taps and all valid flags
// RULE_15 - coefficients and widths fixed, same structure every stage
module fcfir_chain (
  input wire logic clock,
  input wire logic sys_rst,
  input wire fcfir_pkg::fcfir_smp_s in_smp,
  output logic in_ready,
  output fcfir_pkg::fcfir_smp_s out_smp,
  input wire logic out_ready,
  output logic [fcfir_pkg::NSTAGE-1:0] stage_stall,
  output logic overflow
);

  // ==========================================================
  // declarations
  fcfir_pkg::fcfir_chain_s st;
  fcfir_pkg::fcfir_chain_s next_st;

  logic stg_in_valid [fcfir_pkg::NSTAGE];
  fcfir_pkg::fcfir_word_t stg_in_data [fcfir_pkg::NSTAGE];
  logic accept [fcfir_pkg::NSTAGE];
  logic ready_raw [fcfir_pkg::NSTAGE];

  logic fifo_wr_ready [fcfir_pkg::NSTAGE];
  logic fifo_rd_valid [fcfir_pkg::NSTAGE];
  fcfir_pkg::fcfir_word_t fifo_rd_data [fcfir_pkg::NSTAGE];
  logic fifo_rd_ready [fcfir_pkg::NSTAGE];
  logic [fcfir_pkg::FIFO_LW-1:0] fifo_level [fcfir_pkg::NSTAGE];

  // ==========================================================
  // filter arithmetic
  // purely combinational, evaluated every cycle; only the registers
  // around it carry an enable, which keeps the enable fan-out small
  function automatic fcfir_pkg::fcfir_word_t fir_sum(
    input logic [fcfir_pkg::NTAPS-1:0][fcfir_pkg::DW-1:0] tap
  );
    fcfir_pkg::fcfir_acc_t acc;
    acc = '0;
    for (int i = 0; i < fcfir_pkg::NTAPS; i++)
    begin
      // widen both factors first so the product is never cut to 16 bits
      acc = acc +
        fcfir_pkg::fcfir_acc_t'($signed(tap[i])) *
        fcfir_pkg::fcfir_acc_t'($signed(fcfir_pkg::FIR_COEF[i])); // RULE_12
    end
    // plain truncation; the coefficient set keeps the gain at one
    return acc[fcfir_pkg::COEF_FRAC +: fcfir_pkg::DW];
  endfunction

  // ==========================================================
  // stage wiring
  genvar g;
  generate
    for (g = 0; g < fcfir_pkg::NSTAGE; g++)
    begin : g_stage
      if (g == 0)
      begin : g_first
        assign stg_in_valid[g] = in_smp.valid;
        assign stg_in_data[g] = in_smp.data;
      end
      else
      begin : g_next
        assign stg_in_valid[g] = fifo_rd_valid[g - 1];
        assign stg_in_data[g] = fifo_rd_data[g - 1];
      end

      if (g == fcfir_pkg::NSTAGE - 1)
      begin : g_last
        assign fifo_rd_ready[g] = out_ready; // RULE_09
      end
      else
      begin : g_mid
        // the next stage's delayed ready is the only backward signal
        assign fifo_rd_ready[g] =
          st.stg[g + 1].rdy_dly[fcfir_pkg::FB_DELAY-1]; // RULE_06
      end

      assign ready_raw[g] =
        (fifo_level[g] <
         fcfir_pkg::FIFO_LW'(fcfir_pkg::FILL_THRESH)); // RULE_02

      // RULE_01
      fcfir_fifo #(
        .WIDTH(fcfir_pkg::DW),
        .DEPTH(fcfir_pkg::FIFO_DEPTH),
        .LW(fcfir_pkg::FIFO_LW)
      ) u_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .wr_valid(st.stg[g].out_valid),
        .wr_data(st.stg[g].out_data),
        .wr_ready(fifo_wr_ready[g]),
        .rd_valid(fifo_rd_valid[g]),
        .rd_data(fifo_rd_data[g]),
        .rd_ready(fifo_rd_ready[g]),
        .level(fifo_level[g])
      );
    end
  endgenerate

  // ==========================================================
  // next state
  always_comb
  begin
    next_st = st;
    for (int k = 0; k < fcfir_pkg::NSTAGE; k++)
    begin
      // ready seen by the stage is the fill test delayed FB_DELAY
      // cycles; the room above the threshold absorbs what is in
      // flight meanwhile
      next_st.stg[k].rdy_dly =
        {st.stg[k].rdy_dly[fcfir_pkg::FB_DELAY-2:0],
         ready_raw[k]}; // RULE_07 RULE_08

      accept[k] = stg_in_valid[k] &&
        st.stg[k].rdy_dly[fcfir_pkg::FB_DELAY-1]; // RULE_03

      next_st.stg[k].stall = stg_in_valid[k] &&
        !st.stg[k].rdy_dly[fcfir_pkg::FB_DELAY-1];

      // tap line shifts only on an accepted sample
      if (accept[k])
      begin
        next_st.stg[k].tap[0] = stg_in_data[k]; // RULE_11
        for (int i = 1; i < fcfir_pkg::NTAPS; i++)
        begin
          next_st.stg[k].tap[i] = st.stg[k].tap[i - 1]; // RULE_10
        end
      end

      // valid pipelined next to the taps and the output register
      next_st.stg[k].mid_valid = accept[k]; // RULE_13
      next_st.stg[k].out_valid = st.stg[k].mid_valid; // RULE_13
      if (st.stg[k].mid_valid)
      begin
        next_st.stg[k].out_data = fir_sum(st.stg[k].tap); // RULE_10 RULE_15
      end

      // cannot happen with the sizing above; kept as a sticky witness
      if (st.stg[k].out_valid && !fifo_wr_ready[k])
      begin
        next_st.overflow = 1'b1;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int k = 0; k < fcfir_pkg::NSTAGE; k++)
      begin
        for (int i = 0; i < fcfir_pkg::NTAPS; i++)
        begin
          st.stg[k].tap[i] <= fcfir_pkg::TAP_RST; // RULE_14
        end
        st.stg[k].mid_valid <= 1'b0; // RULE_14
        st.stg[k].out_data <= fcfir_pkg::TAP_RST;
        st.stg[k].out_valid <= 1'b0; // RULE_14
        st.stg[k].rdy_dly <= {fcfir_pkg::FB_DELAY{fcfir_pkg::READY_RST}};
        st.stg[k].stall <= 1'b0;
      end
      st.overflow <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs, all taken from flip-flops
  assign in_ready = st.stg[0].rdy_dly[fcfir_pkg::FB_DELAY-1];
  assign out_smp.valid = fifo_rd_valid[fcfir_pkg::NSTAGE-1]; // RULE_13
  assign out_smp.data = fifo_rd_data[fcfir_pkg::NSTAGE-1];
  assign overflow = st.overflow;

  generate
    for (g = 0; g < fcfir_pkg::NSTAGE; g++)
    begin : g_stall
      assign stage_stall[g] = st.stg[g].stall;
    end
  endgenerate

endmodule

// [include/fcfir_pkg.sv]
/*
  shared constants and types of the flow controlled fir chain:
  widths, taps, coefficients, fifo sizing, feedback delay, reset values.
  assumes a single clock domain; all users refer to fcfir_pkg::name.
*/
package fcfir_pkg;

  // ==========================================================
  // datapath sizing
  localparam int NSTAGE = 3;
  localparam int DW = 16;
  localparam int CW = 16;
  localparam int NTAPS = 4;
  localparam int COEF_FRAC = 15;
  localparam int ACCW = DW + CW + 2;

  // q1.15 coefficients, unity dc gain; same set in every stage
  localparam logic [NTAPS-1:0][CW-1:0] FIR_COEF =
    {16'h1000, 16'h3000, 16'h3000, 16'h1000};

  // ==========================================================
  // fifo and flow control sizing
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_LW = 4;
  // stop threshold at half capacity
  localparam int FILL_THRESH = FIFO_DEPTH / 2;
  // tap register plus output register
  localparam int FIR_LAT = 2;
  // feedback delay matches the stage latency
  localparam int FB_DELAY = FIR_LAT;
  // words that may still land after the threshold: FB_DELAY + FIR_LAT,
  // which must not exceed FIFO_DEPTH - FILL_THRESH
  localparam int FIFO_ROOM = FIFO_DEPTH - FILL_THRESH;

  // ==========================================================
  // reset values
  localparam logic [DW-1:0] TAP_RST = 16'h0000;
  localparam logic READY_RST = 1'b0;

  // ==========================================================
  // types
  typedef logic signed [ACCW-1:0] fcfir_acc_t;
  typedef logic [DW-1:0] fcfir_word_t;

  typedef struct packed {
    logic valid;
    fcfir_word_t data;
  } fcfir_smp_s;

  typedef struct packed {
    logic [NTAPS-1:0][DW-1:0] tap;
    logic mid_valid;
    fcfir_word_t out_data;
    logic out_valid;
    logic [FB_DELAY-1:0] rdy_dly;
    logic stall;
  } fcfir_stage_s;

  typedef struct packed {
    fcfir_stage_s [NSTAGE-1:0] stg;
    logic overflow;
  } fcfir_chain_s;

endpackage

// [rtl/fcfir_fifo.sv]
/*
  shift register fifo: entry 0 is always the oldest word, so the head
  leaves straight from a flip-flop.
  assumes one clock and an asynchronous active high reset.
*/
`timescale 1ns/100ps
module fcfir_fifo #(
  parameter int WIDTH = fcfir_pkg::DW,
  parameter int DEPTH = fcfir_pkg::FIFO_DEPTH,
  parameter int LW = fcfir_pkg::FIFO_LW
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data,
  input wire logic rd_ready,
  output logic [LW-1:0] level
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [LW-1:0] count;
    logic head_valid;
  } fcfir_fifo_st_s;

  fcfir_fifo_st_s st;
  fcfir_fifo_st_s next_st;
  logic push;
  logic pop;
  logic [LW-1:0] widx;

  // ==========================================================
  // next state
  always_comb
  begin
    next_st = st;
    push = wr_valid && (st.count != LW'(DEPTH));
    pop = st.head_valid && rd_ready; // RULE_05
    widx = pop ? st.count - LW'(1) : st.count;
    if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        next_st.mem[i] = st.mem[i + 1];
      end
    end
    if (push)
    begin
      next_st.mem[widx] = wr_data;
    end
    next_st.count = st.count + LW'(push) - LW'(pop);
    next_st.head_valid = (next_st.count != '0); // RULE_04
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0; // RULE_14
    end
    else
    begin
      st <= next_st;
    end
  end

  assign wr_ready = (st.count != LW'(DEPTH));
  assign rd_valid = st.head_valid; // RULE_04
  assign rd_data = st.mem[0];
  assign level = st.count;

endmodule

// [dv/fcfir_chain_sva.sv]
/*
  checker for the fir chain ports, bound into fcfir_chain.
  assumes one clock and sys_rst active high.
*/
`timescale 1ns/100ps
module fcfir_chain_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire fcfir_pkg::fcfir_smp_s in_smp,
  input wire logic in_ready,
  input wire fcfir_pkg::fcfir_smp_s out_smp,
  input wire logic out_ready,
  input wire logic [fcfir_pkg::NSTAGE-1:0] stage_stall,
  input wire logic overflow
);
  // ==========================================================
  // words inside the chain; each accepted sample leaves exactly once
  logic [5:0] occ;
  logic take, pop, blk;
  assign take = in_smp.valid && in_ready;
  assign pop = out_smp.valid && out_ready;
  assign blk = in_smp.valid && !in_ready;
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      occ <= 6'h00;
    else
      occ <= occ + 6'(take) - 6'(pop);
  // ==========================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_hold;
    out_smp.valid && !out_ready |=> out_smp.valid && $stable(out_smp.data);
  endproperty
  a_hold: assert property (p_hold) else $error("head moved");
  property p_stall;
    1'b1 |=> stage_stall[0] == $past(blk);
  endproperty
  a_stall: assert property (p_stall) else $error("stall flag");
  property p_no_ovf;
    !overflow;
  endproperty
  a_no_ovf: assert property (p_no_ovf) else $error("overflow");
  property p_occ_max;
    occ <= 6'h1E;
  endproperty
  a_occ_max: assert property (p_occ_max) else $error("too full");
  property p_no_ghost;
    occ == 6'h00 |-> !out_smp.valid;
  endproperty
  a_no_ghost: assert property (p_no_ghost) else $error("ghost");
  property p_progress;
    occ != 6'h00 |-> ##[0:12] out_smp.valid;
  endproperty
  a_progress: assert property (p_progress) else $error("stuck");
  property p_last_pop;
    pop && occ == 6'h01 |=> !out_smp.valid;
  endproperty
  a_last_pop: assert property (p_last_pop) else $error("pop");
  property p_ready_back;
    occ == 6'h00 |-> ##[0:2] in_ready;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("rdy");
  c_pop: cover property (pop);
  c_blk: cover property (blk);
  c_stop: cover property ($fell(in_ready));
endmodule
bind fcfir_chain fcfir_chain_chk u_chk (.clock(clock), .sys_rst(sys_rst),
  .in_smp(in_smp), .in_ready(in_ready), .out_smp(out_smp),
  .out_ready(out_ready), .stage_stall(stage_stall), .overflow(overflow));

// [dv/fcfir_sink.sv]
/*
  downstream consumer model: drives ready, collects popped words.
  assumes mode 0 ready, 1 stalled, 2 ready every other cycle.
*/
`timescale 1ns/100ps
module fcfir_sink (
  input wire logic clock,
  input wire logic sys_rst,
  input wire fcfir_pkg::fcfir_smp_s out_smp,
  input wire logic [1:0] mode,
  output logic out_ready
);
  logic [15:0] got[$];
  logic ph = 1'b0;
  initial out_ready = 1'b0;
  // ==========================================================
  // ready moves on the falling edge, away from the sampling edge
  always @(negedge clock)
  begin
    ph <= ~ph;
    out_ready <= (mode == 2'h0) || (mode == 2'h2 && ph);
  end
  // data counts only in cycles with valid and ready both high
  always @(posedge clock)
    if (!sys_rst && out_smp.valid && out_ready)
      got.push_back(out_smp.data);
endmodule

// [dv/fcfir_chain_tb.sv]
/*
  self-checking bench of the fir chain with a reference model.
  assumes fcfir_sink as consumer; inputs move on the falling edge.
*/
`timescale 1ns/100ps
module fcfir_chain_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  fcfir_pkg::fcfir_smp_s in_smp = '0;
  fcfir_pkg::fcfir_smp_s out_smp;
  logic in_ready, out_ready, overflow;
  logic [2:0] stage_stall;
  logic [1:0] mode = 2'h0;
  int miscompares = 0;
  int samples_checked = 0;
  logic [15:0] exp_q[$];
  logic signed [15:0] hist[3][4] = '{default: '0};
  initial forever #12.5 clock = ~clock;
  fcfir_chain u_dut (.clock(clock), .sys_rst(sys_rst), .in_smp(in_smp),
    .in_ready(in_ready), .out_smp(out_smp), .out_ready(out_ready),
    .stage_stall(stage_stall), .overflow(overflow));
  fcfir_sink u_sink (.clock(clock), .sys_rst(sys_rst), .out_smp(out_smp),
    .mode(mode), .out_ready(out_ready));
  // ==========================================================
  task check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      miscompares++;
      $display("Error t=%0t got %h want %h", $time, seen, want);
    end
  endtask
  task conclude;
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // three stages of the filter, taps move only on accepted samples
  function automatic logic [15:0] ref_chain(input logic [15:0] x);
    logic signed [33:0] acc;
    logic [15:0] v;
    v = x;
    for (int s = 0; s < 3; s++)
    begin
      for (int k = 3; k > 0; k--)
        hist[s][k] = hist[s][k-1];
      hist[s][0] = v;
      acc = '0;
      for (int k = 0; k < 4; k++)
        acc += hist[s][k] * $signed({1'b0, fcfir_pkg::FIR_COEF[k]});
      v = acc[30:15];
    end
    return v;
  endfunction
  // valid stays up until taken or lim cycles pass; a refused word is dropped, not offered again
  task send(input logic [15:0] d, input int lim, output bit ok);
    in_smp.valid = 1'b1;
    in_smp.data = d;
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++)
    begin
      ok = in_ready;
      @(negedge clock);
    end
    if (ok)
      exp_q.push_back(ref_chain(d));
  endtask
  task drain;
    int i;
    i = 0;
    in_smp.valid = 1'b0;
    in_smp.data = ~in_smp.data;
    while (u_sink.got.size() < exp_q.size() && i < 600)
    begin
      @(negedge clock);
      i++;
    end
    check(16'(u_sink.got.size()), 16'(exp_q.size()));
    while (exp_q.size() > 0)
      check(u_sink.got.pop_front(), exp_q.pop_front());
    if (i >= 600)
      conclude();
  endtask
  // ==========================================================
  task t_latency;
    int n;
    bit ok;
    n = 0;
    send(16'h4000, 20, ok);
    in_smp.valid = 1'b0;
    while (!out_smp.valid && n < 40)
    begin
      @(negedge clock);
      n++;
    end
    check(16'(n), 16'h0008);
    drain();
  endtask
  task t_backpressure;
    bit ok;
    int i;
    i = 0;
    ok = 1'b1;
    mode = 2'h1;
    while (ok && i < 60)
    begin
      send(16'(i * 32'h1357), 20, ok);
      i += ok;
    end
    check({15'h0, in_ready}, 16'h0000);
    check({13'h0, stage_stall}, 16'h0007);
    mode = 2'h2;
    for (int j = 0; j < 24; j++)
    begin
      send(16'((i + j) * 32'h1357), 200, ok);
      if (j % 3 == 0)
      begin
        in_smp.valid = 1'b0;
        @(negedge clock);
      end
    end
    drain();
    check({15'h0, overflow}, 16'h0000);
  endtask
  // reset with words in flight must leave no trace in later output
  task t_midreset;
    bit ok;
    mode = 2'h1;
    for (int i = 0; i < 10; i++)
      send(16'h7FFF, 20, ok);
    in_smp.valid = 1'b0;
    sys_rst = 1'b1;
    @(negedge clock);
    check({15'h0, out_smp.valid}, 16'h0000);
    check({15'h0, in_ready}, 16'h0000);
    exp_q.delete();
    u_sink.got.delete();
    hist = '{default: '0};
    sys_rst = 1'b0;
    mode = 2'h0;
  endtask
  initial
  begin
    repeat (5) @(negedge clock);
    check({15'h0, out_smp.valid}, 16'h0000);
    sys_rst = 1'b0;
    t_latency();
    t_backpressure();
    t_midreset();
    t_latency();
    conclude();
  end
endmodule
